// >>> hdl/hbu_pkg.sv
// package: register map, field positions, reset values and carrier types of the breakpoint unit
package hbu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets (one aligned 32-bit word each)
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_MATCH_ADDR_HIGH = 8'h08;
  localparam logic [7:0] OFS_MATCH_ADDR_LOW = 8'h0C;
  localparam logic [7:0] OFS_MATCH_DATA_HIGH = 8'h10;
  localparam logic [7:0] OFS_MATCH_DATA_LOW = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // breakpoint_control_a field positions
  localparam int CA_MODE_SEL_HI = 7;
  localparam int CA_MODE_SEL_LO = 6;
  localparam int CA_PROGRAM_ONLY = 5;
  localparam int CA_BP1_LOW_ADDR_EN = 1;
  localparam int CA_BP0_LOW_ADDR_EN = 0;
  localparam logic [7:0] CA_WMASK = 8'hE3;

  // breakpoint_control_b field positions
  localparam int CB_SECOND_CMP_EN = 7;
  localparam int CB_DATA_HIGH_MASK = 6;
  localparam int CB_DATA_LOW_MASK = 5;
  localparam int CB_BP1_DIR_CMP_EN = 3;
  localparam int CB_BP1_DIR_VALUE = 2;
  localparam int CB_BP0_DIR_CMP_EN = 1;
  localparam int CB_BP0_DIR_VALUE = 0;
  localparam logic [7:0] CB_WMASK = 8'hEF;

  // status field positions
  localparam int ST_PENDING = 0;
  localparam int ST_TAGS_HELD = 1;
  localparam int ST_LAST_BP0 = 2;
  localparam int ST_LAST_BP1 = 3;
  localparam int ST_LAST_SWI = 4;
  localparam int ST_LAST_DEBUG = 5;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // direction value: 1 matches a read cycle, 0 a write cycle
  localparam logic DIR_READ = 1'b1;

  typedef enum logic [1:0] {
    HBU_MODE_OFF = 2'b00,
    HBU_MODE_SWI_DUAL = 2'b01,
    HBU_MODE_FULL = 2'b10,
    HBU_MODE_DBG_DUAL = 2'b11
  } hbu_mode_t;

  // one core bus cycle as seen by the comparators
  typedef struct packed {
    logic cyc;
    logic fetch;
    logic rw;
    logic [15:0] addr;
    logic [15:0] data;
  } hbu_bus_t;

  // break requests towards the core
  typedef struct packed {
    logic swi;
    logic debug;
  } hbu_break_t;

endpackage

// >>> hdl/hbu_byte_cmp.sv
// module: one byte comparator that reports a match when disabled or equal
`timescale 1ns/1ps
module hbu_byte_cmp #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] bus_i,
  input wire logic [WIDTH-1:0] ref_i,
  input wire logic en_i,
  output logic match_o
);

  // a disabled byte never blocks the breakpoint
  assign match_o = !en_i || (bus_i == ref_i);

endmodule

// >>> hdl/hbu_tag_queue.sv
// module: tag bits that travel alongside the instruction queue
`timescale 1ns/1ps
module hbu_tag_queue #(
  parameter int DEPTH = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic load_i,
  input wire logic tag_i,
  input wire logic advance_i,
  output logic head_hit_o,
  output logic busy_o
);

  logic [DEPTH-1:0] tags_reg;
  logic [DEPTH-1:0] tags_next;

  always_comb begin
    tags_next = tags_reg;
    if (advance_i) begin
      tags_next = {1'b0, tags_reg[DEPTH-1:1]};
    end
    if (load_i) begin
      tags_next[DEPTH-1] = tag_i;
    end
  end

  // flush drops tags of opcodes that will never execute
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tags_reg <= '0;
    end else if (flush_i) begin
      tags_reg <= '0;
    end else begin
      tags_reg <= tags_next;
    end
  end

  assign head_hit_o = advance_i && tags_reg[0] && !flush_i;
  assign busy_o = |tags_reg;

endmodule

// >>> hdl/hbu_top.sv
// module: hardware breakpoint unit with its axi4-lite register slave
`timescale 1ns/1ps
module hbu_top #(
  parameter int QUEUE_DEPTH = 3
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic PWR_ON_RST_I,
  // core side
  input wire hbu_pkg::hbu_bus_t BUS_I,
  input wire logic INSN_BOUNDARY_I,
  input wire logic QUEUE_ADV_I,
  input wire logic QUEUE_FLUSH_I,
  input wire logic DEBUG_ACTIVE_I,
  input wire logic DEBUG_PERMIT_I,
  output hbu_pkg::hbu_break_t BREAK_O,
  // axi4-lite slave
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] ctrl_a_reg;
  logic [7:0] ctrl_b_reg;
  logic [7:0] match_addr_high_reg;
  logic [7:0] match_addr_low_reg;
  logic [7:0] match_data_high_reg;
  logic [7:0] match_data_low_reg;
  logic pending_reg;
  logic last_bp0_reg;
  logic last_bp1_reg;
  logic [1:0] last_kind_reg;
  hbu_pkg::hbu_break_t break_reg;

  // axi slave state
  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // control field decode

  hbu_pkg::hbu_mode_t mode;
  logic program_only_break;
  logic bp1_low_addr_en;
  logic bp0_low_addr_en;
  logic second_cmp_en;
  logic data_high_mask;
  logic data_low_mask;
  logic bp1_dir_cmp_en;
  logic bp1_dir_value;
  logic bp0_dir_cmp_en;
  logic bp0_dir_value;

  assign mode = hbu_pkg::hbu_mode_t'({ctrl_a_reg[hbu_pkg::CA_MODE_SEL_HI],
                                      ctrl_a_reg[hbu_pkg::CA_MODE_SEL_LO]});
  assign program_only_break = ctrl_a_reg[hbu_pkg::CA_PROGRAM_ONLY];
  assign bp1_low_addr_en = ctrl_a_reg[hbu_pkg::CA_BP1_LOW_ADDR_EN];
  assign bp0_low_addr_en = ctrl_a_reg[hbu_pkg::CA_BP0_LOW_ADDR_EN];
  assign second_cmp_en = ctrl_b_reg[hbu_pkg::CB_SECOND_CMP_EN];
  assign data_high_mask = ctrl_b_reg[hbu_pkg::CB_DATA_HIGH_MASK];
  assign data_low_mask = ctrl_b_reg[hbu_pkg::CB_DATA_LOW_MASK];
  assign bp1_dir_cmp_en = ctrl_b_reg[hbu_pkg::CB_BP1_DIR_CMP_EN];
  assign bp1_dir_value = ctrl_b_reg[hbu_pkg::CB_BP1_DIR_VALUE];
  assign bp0_dir_cmp_en = ctrl_b_reg[hbu_pkg::CB_BP0_DIR_CMP_EN];
  assign bp0_dir_value = ctrl_b_reg[hbu_pkg::CB_BP0_DIR_VALUE];

  logic mode_swi;
  logic mode_full;
  logic mode_dbg_dual;
  logic mode_dual;
  logic prog_break;

  always_comb begin
    mode_swi = 1'b0;
    mode_full = 1'b0;
    mode_dbg_dual = 1'b0;
    case (mode)
      hbu_pkg::HBU_MODE_SWI_DUAL: mode_swi = 1'b1;
      hbu_pkg::HBU_MODE_FULL: mode_full = 1'b1;
      hbu_pkg::HBU_MODE_DBG_DUAL: mode_dbg_dual = 1'b1;
      default: mode_swi = 1'b0;
    endcase
  end

  assign mode_dual = mode_swi || mode_dbg_dual;
  // swi dual always tags fetches, whatever program-only says
  assign prog_break = mode_swi || ((mode_full || mode_dbg_dual) && program_only_break);

  //////////////////////////////////////////////////////////////////////////////
  // comparators

  logic addr_hi_match;
  logic addr_lo_match;
  logic second_hi_match;
  logic second_lo_match;
  logic second_lo_en;
  logic second_hi_en;
  logic [15:0] second_bus;

  // full mode compares data, dual modes compare address
  assign second_bus = mode_full ? BUS_I.data : BUS_I.addr;

  always_comb begin
    second_hi_en = 1'b0;
    second_lo_en = 1'b0;
    if (mode_full) begin
      second_hi_en = second_cmp_en && !program_only_break && !data_high_mask;
      second_lo_en = second_cmp_en && !program_only_break && !data_low_mask;
    end else if (mode_dual) begin
      second_hi_en = second_cmp_en;
      second_lo_en = second_cmp_en && bp1_low_addr_en;
    end
  end

  hbu_byte_cmp #(.WIDTH(8)) u_cmp_addr_hi (
    .bus_i(BUS_I.addr[15:8]),
    .ref_i(match_addr_high_reg),
    .en_i(1'b1),
    .match_o(addr_hi_match)
  );

  // low byte excluded gives the 256-byte range compare
  hbu_byte_cmp #(.WIDTH(8)) u_cmp_addr_lo (
    .bus_i(BUS_I.addr[7:0]),
    .ref_i(match_addr_low_reg),
    .en_i(bp0_low_addr_en),
    .match_o(addr_lo_match)
  );

  hbu_byte_cmp #(.WIDTH(8)) u_cmp_second_hi (
    .bus_i(second_bus[15:8]),
    .ref_i(match_data_high_reg),
    .en_i(second_hi_en),
    .match_o(second_hi_match)
  );

  hbu_byte_cmp #(.WIDTH(8)) u_cmp_second_lo (
    .bus_i(second_bus[7:0]),
    .ref_i(match_data_low_reg),
    .en_i(second_lo_en),
    .match_o(second_lo_match)
  );

  // direction qualification, dropped for program breaks
  logic dir0_ok;
  logic dir1_ok;

  assign dir0_ok = !(bp0_dir_cmp_en && !prog_break) || (BUS_I.rw == bp0_dir_value);
  assign dir1_ok = !(bp1_dir_cmp_en && mode_dbg_dual && !prog_break)
                   || (BUS_I.rw == bp1_dir_value);

  //////////////////////////////////////////////////////////////////////////////
  // hit detection

  logic cycle_ok;
  logic bp0_hit;
  logic bp1_hit;
  logic any_hit;

  // no compare at all during background debug mode
  assign cycle_ok = BUS_I.cyc && !DEBUG_ACTIVE_I && (!prog_break || BUS_I.fetch);

  always_comb begin
    bp0_hit = 1'b0;
    bp1_hit = 1'b0;
    if (cycle_ok && mode_full) begin
      bp0_hit = addr_hi_match && addr_lo_match && dir0_ok
                && second_hi_match && second_lo_match;
    end else if (cycle_ok && mode_dual) begin
      bp0_hit = addr_hi_match && addr_lo_match && dir0_ok;
      bp1_hit = second_cmp_en && second_hi_match && second_lo_match && dir1_ok;
    end
  end

  assign any_hit = bp0_hit || bp1_hit;

  //////////////////////////////////////////////////////////////////////////////
  // program breaks: tag the fetched opcode and break when it reaches the head

  logic tag_head_hit;
  logic tags_busy;

  hbu_tag_queue #(.DEPTH(QUEUE_DEPTH)) u_tag_queue (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .flush_i(QUEUE_FLUSH_I || DEBUG_ACTIVE_I || !prog_break),
    .load_i(BUS_I.cyc && BUS_I.fetch && prog_break),
    .tag_i(any_hit),
    .advance_i(QUEUE_ADV_I),
    .head_hit_o(tag_head_hit),
    .busy_o(tags_busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  // data breaks: held until the next instruction boundary

  logic data_fire;
  logic fire;

  // a pending data break from the previous mode must not fire once tagging rules
  assign data_fire = INSN_BOUNDARY_I && !prog_break && (pending_reg || any_hit);
  assign fire = (data_fire || tag_head_hit) && !DEBUG_ACTIVE_I;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pending_reg <= 1'b0;
    end else if (DEBUG_ACTIVE_I || prog_break || mode == hbu_pkg::HBU_MODE_OFF) begin
      pending_reg <= 1'b0;
    end else if (any_hit && !INSN_BOUNDARY_I) begin
      pending_reg <= 1'b1;
    end else if (INSN_BOUNDARY_I) begin
      pending_reg <= 1'b0;
    end
  end

  // the firmware loops if permit is clear, so entry is simply withheld
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      break_reg <= '0;
    end else begin
      break_reg.swi <= fire && mode_swi;
      break_reg.debug <= fire && (mode_full || mode_dbg_dual) && DEBUG_PERMIT_I;
    end
  end

  assign BREAK_O = break_reg;

  // which comparator last hit, and what the last break raised
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      last_bp0_reg <= 1'b0;
      last_bp1_reg <= 1'b0;
    end else if (any_hit) begin
      last_bp0_reg <= bp0_hit;
      last_bp1_reg <= bp1_hit;
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      last_kind_reg <= 2'h0;
    end else if (break_reg.swi || break_reg.debug) begin
      last_kind_reg <= {break_reg.debug, break_reg.swi};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path: address and data taken in either order

  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_known;

  assign S_AXI_AWREADY_O = !aw_held_reg && !bvalid_reg;
  assign S_AXI_WREADY_O = !w_held_reg && !bvalid_reg;
  assign wr_addr = aw_held_reg ? awaddr_reg : S_AXI_AWADDR_I;
  assign wr_data = w_held_reg ? wdata_reg : S_AXI_WDATA_I;
  assign do_write = (aw_held_reg || (S_AXI_AWVALID_I && S_AXI_AWREADY_O))
                    && (w_held_reg || (S_AXI_WVALID_I && S_AXI_WREADY_O));
  assign wr_known = (wr_addr == hbu_pkg::OFS_CTRL_A) || (wr_addr == hbu_pkg::OFS_CTRL_B)
                    || (wr_addr == hbu_pkg::OFS_MATCH_ADDR_HIGH)
                    || (wr_addr == hbu_pkg::OFS_MATCH_ADDR_LOW)
                    || (wr_addr == hbu_pkg::OFS_MATCH_DATA_HIGH)
                    || (wr_addr == hbu_pkg::OFS_MATCH_DATA_LOW)
                    || (wr_addr == hbu_pkg::OFS_STATUS);

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      wdata_reg <= hbu_pkg::RDATA_RST;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA_I;
      end
    end
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= hbu_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_known ? hbu_pkg::RESP_OKAY : hbu_pkg::RESP_DECERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_BRESP_O = bresp_reg;

  // control registers take writes in any operating mode
  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_a_reg <= hbu_pkg::CTRL_A_RST;
      ctrl_b_reg <= hbu_pkg::CTRL_B_RST;
    end else if (do_write && S_AXI_WSTRB_I[0]) begin
      if (wr_addr == hbu_pkg::OFS_CTRL_A) begin
        ctrl_a_reg <= wr_data[7:0] & hbu_pkg::CA_WMASK;
      end
      if (wr_addr == hbu_pkg::OFS_CTRL_B) begin
        ctrl_b_reg <= wr_data[7:0] & hbu_pkg::CB_WMASK;
      end
    end
  end

  // match values survive an ordinary reset; only power-on clears them
  always_ff @(posedge MCLK_I or posedge PWR_ON_RST_I) begin
    if (PWR_ON_RST_I) begin
      match_addr_high_reg <= hbu_pkg::MATCH_RST;
      match_addr_low_reg <= hbu_pkg::MATCH_RST;
      match_data_high_reg <= hbu_pkg::MATCH_RST;
      match_data_low_reg <= hbu_pkg::MATCH_RST;
    end else if (do_write && S_AXI_WSTRB_I[0]) begin
      if (wr_addr == hbu_pkg::OFS_MATCH_ADDR_HIGH) begin
        match_addr_high_reg <= wr_data[7:0];
      end
      if (wr_addr == hbu_pkg::OFS_MATCH_ADDR_LOW) begin
        match_addr_low_reg <= wr_data[7:0];
      end
      if (wr_addr == hbu_pkg::OFS_MATCH_DATA_HIGH) begin
        match_data_high_reg <= wr_data[7:0];
      end
      if (wr_addr == hbu_pkg::OFS_MATCH_DATA_LOW) begin
        match_data_low_reg <= wr_data[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  logic [7:0] status;
  logic [31:0] rd_word;
  logic rd_known;

  always_comb begin
    status = 8'h00;
    status[hbu_pkg::ST_PENDING] = pending_reg;
    status[hbu_pkg::ST_TAGS_HELD] = tags_busy;
    status[hbu_pkg::ST_LAST_BP0] = last_bp0_reg;
    status[hbu_pkg::ST_LAST_BP1] = last_bp1_reg;
    status[hbu_pkg::ST_LAST_SWI] = last_kind_reg[0];
    status[hbu_pkg::ST_LAST_DEBUG] = last_kind_reg[1];
  end

  always_comb begin
    rd_word = hbu_pkg::RDATA_RST;
    rd_known = 1'b1;
    case (S_AXI_ARADDR_I)
      hbu_pkg::OFS_CTRL_A: rd_word[7:0] = ctrl_a_reg;
      hbu_pkg::OFS_CTRL_B: rd_word[7:0] = ctrl_b_reg;
      hbu_pkg::OFS_MATCH_ADDR_HIGH: rd_word[7:0] = match_addr_high_reg;
      hbu_pkg::OFS_MATCH_ADDR_LOW: rd_word[7:0] = match_addr_low_reg;
      hbu_pkg::OFS_MATCH_DATA_HIGH: rd_word[7:0] = match_data_high_reg;
      hbu_pkg::OFS_MATCH_DATA_LOW: rd_word[7:0] = match_data_low_reg;
      hbu_pkg::OFS_STATUS: rd_word[7:0] = status;
      default: rd_known = 1'b0;
    endcase
  end

  assign S_AXI_ARREADY_O = !rvalid_reg;

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= hbu_pkg::RESP_OKAY;
      rdata_reg <= hbu_pkg::RDATA_RST;
    end else if (S_AXI_ARVALID_I && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_known ? hbu_pkg::RESP_OKAY : hbu_pkg::RESP_DECERR;
      rdata_reg <= rd_word;
    end else if (S_AXI_RREADY_I) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID_O = rvalid_reg;
  assign S_AXI_RRESP_O = rresp_reg;
  assign S_AXI_RDATA_O = rdata_reg;

endmodule

// >>> dv/hbu_properties.sv
// checker: port-level timing and break-cause properties of the breakpoint unit
`timescale 1ns/1ps
module hbu_properties (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic INSN_BOUNDARY_I,
  input wire logic QUEUE_ADV_I,
  input wire logic DEBUG_ACTIVE_I,
  input wire logic DEBUG_PERMIT_I,
  input wire hbu_pkg::hbu_break_t BREAK_O,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  ////////////////////////////////////////
  sequence s_wr_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence s_dbg_held;
    $past(DEBUG_ACTIVE_I, 2) && $past(DEBUG_ACTIVE_I);
  endsequence
  property p_one_kind; !(BREAK_O.swi && BREAK_O.debug); endproperty
  a_one_kind: assert property (p_one_kind) else $error("both break kinds at once");
  property p_quiet_dbg; s_dbg_held |-> BREAK_O == '0; endproperty
  a_quiet_dbg: assert property (p_quiet_dbg) else $error("break while debug active");
  property p_permit; BREAK_O.debug |-> $past(DEBUG_PERMIT_I); endproperty
  a_permit: assert property (p_permit) else $error("debug break without permit");
  property p_swi_adv; BREAK_O.swi |-> $past(QUEUE_ADV_I); endproperty
  a_swi_adv: assert property (p_swi_adv) else $error("swi not from queue head");
  property p_dbg_cause; BREAK_O.debug |-> $past(QUEUE_ADV_I) || $past(INSN_BOUNDARY_I); endproperty
  a_dbg_cause: assert property (p_dbg_cause) else $error("debug break off boundary");
  property p_wr_resp; s_wr_taken |=> S_AXI_BVALID_O; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp; S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  property p_ar_block; S_AXI_RVALID_O |-> !S_AXI_ARREADY_O; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
endmodule

// >>> dv/hbu_core_model.sv
// partner model: processor core bus cycles, instruction queue and debug lines
`timescale 1ns/1ps
module hbu_core_model (
  input wire logic clk_i,
  output hbu_pkg::hbu_bus_t bus_o,
  output logic boundary_o,
  output logic adv_o,
  output logic flush_o,
  output logic active_o,
  output logic permit_o
);
  initial begin
    bus_o = '0;
    {boundary_o, adv_o, flush_o, active_o} = 4'h0;
    permit_o = 1'b1;
  end
  // a released bus shows the inverted value so a stale match cannot linger
  task cycle(input logic [1:0] fr, input logic [31:0] ad);
    bus_o <= {1'b1, fr, ad};
    @(posedge clk_i);
    bus_o <= {1'b0, fr, ~ad};
  endtask
  task lines(input logic [1:0] ap);
    {active_o, permit_o} <= ap;
  endtask
  task step(input logic [2:0] s);
    {boundary_o, adv_o, flush_o} <= s;
    @(posedge clk_i);
  endtask
endmodule

// >>> dv/test_hardware_breakpoint_unit.sv
// testbench: register access and breakpoint scenarios of the breakpoint unit
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module test_hardware_breakpoint_unit;
  localparam int QD = 3;
  logic clk = 1'b0, rst = 1'b1, por = 1'b1;
  hbu_pkg::hbu_bus_t bus;
  hbu_pkg::hbu_break_t brk;
  logic bnd, adv, flush, act, perm;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic aw = 1'b0, w = 1'b0, bready = 1'b0, ar = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [15:0] cnt;
  int failures = 0, num_checks = 0;
  always #4 clk = ~clk;
  // pulse counts per kind, so a stretched pulse shows as a wrong count
  always @(posedge clk) cnt <= rst ? 16'h0 : cnt + {7'h0, brk.swi, 7'h0, brk.debug};
  hbu_core_model u_core (.clk_i(clk), .bus_o(bus), .boundary_o(bnd), .adv_o(adv),
    .flush_o(flush), .active_o(act), .permit_o(perm));
  hbu_top #(.QUEUE_DEPTH(QD)) u_dut (.MCLK_I(clk), .SYS_RST_I(rst), .PWR_ON_RST_I(por),
    .BUS_I(bus), .INSN_BOUNDARY_I(bnd), .QUEUE_ADV_I(adv), .QUEUE_FLUSH_I(flush),
    .DEBUG_ACTIVE_I(act), .DEBUG_PERMIT_I(perm), .BREAK_O(brk), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(aw), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(w), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
    .S_AXI_ARVALID_I(ar), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready));
  ////////////////////////////////////////
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    {aw, w, bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (aw && awready) aw <= 1'b0;
      if (w && wready) w <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        `CHK(bresp, er)
      end
    end while (aw || w || bready);
    // let an edge pass so a back-to-back call never re-raises bready in this step
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    {ar, rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (ar && arready) ar <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        `CHK(rdata, e)
        `CHK(rresp, er)
      end
    end while (ar || rready);
    @(posedge clk);
  endtask
  // pa: flush, debug active, permit; fr: fetch, read; e: swi, debug
  task hit(input logic [7:0] a, input logic [7:0] b, input logic [2:0] pa,
    input logic [1:0] fr, input logic [31:0] ad, input logic [1:0] e);
    logic [15:0] c0;
    wr(8'h00, {24'h0, a}, 2'h0);
    wr(8'h04, {24'h0, b}, 2'h0);
    u_core.lines(pa[1:0]);
    c0 = cnt;
    u_core.cycle(fr, ad);
    u_core.step({1'b1, 1'b0, pa[2]});
    repeat (QD) u_core.step(3'h2);
    u_core.step(3'h0);
    repeat (2) @(posedge clk);
    `CHK(cnt - c0, {7'h0, e[1], 7'h0, e[0]})
  endtask
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    rd(8'h04, 32'h0, 2'h0);
    wr(8'h00, 32'hFF, 2'h0);
    rd(8'h00, {24'h0, hbu_pkg::CA_WMASK}, 2'h0);
    wr(8'h40, 32'hFF, 2'h3);
    rd(8'h40, 32'h0, 2'h3);
    wr(8'h08, 32'h12, 2'h0);
    wr(8'h0C, 32'h34, 2'h0);
    wr(8'h10, 32'hAB, 2'h0);
    wr(8'h14, 32'hCD, 2'h0);
    hit(8'h81, 8'h83, 3'h1, 2'h1, 32'h1234ABCD, 2'h1);
    hit(8'h81, 8'h83, 3'h1, 2'h0, 32'h1234ABCD, 2'h0);
    hit(8'h81, 8'h83, 3'h1, 2'h1, 32'h1234AB00, 2'h0);
    hit(8'h81, 8'hA3, 3'h1, 2'h1, 32'h1234AB00, 2'h1);
    hit(8'h81, 8'hC3, 3'h1, 2'h1, 32'h123400CD, 2'h1);
    hit(8'h80, 8'h83, 3'h1, 2'h1, 32'h12FFABCD, 2'h1);
    hit(8'h81, 8'h03, 3'h1, 2'h1, 32'h12340000, 2'h1);
    hit(8'h83, 8'h8B, 3'h1, 2'h1, 32'h1234ABCD, 2'h1);
    hit(8'h81, 8'h83, 3'h0, 2'h1, 32'h1234ABCD, 2'h0);
    hit(8'h81, 8'h83, 3'h3, 2'h1, 32'h1234ABCD, 2'h0);
    hit(8'hA1, 8'h83, 3'h1, 2'h3, 32'h12340000, 2'h1);
    hit(8'h41, 8'h00, 3'h1, 2'h3, 32'h12340000, 2'h2);
    hit(8'h41, 8'h00, 3'h1, 2'h1, 32'h12340000, 2'h0);
    hit(8'h43, 8'h80, 3'h1, 2'h3, 32'hABCD0000, 2'h2);
    hit(8'h43, 8'h00, 3'h1, 2'h3, 32'hABCD0000, 2'h0);
    hit(8'h42, 8'h80, 3'h1, 2'h3, 32'hAB000000, 2'h0);
    hit(8'h60, 8'hEA, 3'h1, 2'h3, 32'h12340000, 2'h2);
    hit(8'hC3, 8'h8C, 3'h1, 2'h1, 32'hABCD0000, 2'h1);
    hit(8'hC3, 8'h8C, 3'h1, 2'h0, 32'hABCD0000, 2'h0);
    hit(8'hE1, 8'h00, 3'h1, 2'h3, 32'h12340000, 2'h1);
    hit(8'hE1, 8'h00, 3'h5, 2'h3, 32'h12340000, 2'h0);
    hit(8'h01, 8'h00, 3'h1, 2'h3, 32'h12340000, 2'h0);
    rd(8'h18, 32'h24, 2'h0);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h08, 32'h12, 2'h0);
    rd(8'h00, 32'h0, 2'h0);
    por <= 1'b1;
    repeat (3) @(posedge clk);
    por <= 1'b0;
    @(posedge clk);
    rd(8'h14, 32'h0, 2'h0);
    results();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    results();
  end
endmodule
bind hbu_top hbu_properties u_chk (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
  .INSN_BOUNDARY_I(INSN_BOUNDARY_I), .QUEUE_ADV_I(QUEUE_ADV_I),
  .DEBUG_ACTIVE_I(DEBUG_ACTIVE_I), .DEBUG_PERMIT_I(DEBUG_PERMIT_I), .BREAK_O(BREAK_O),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O));
